/* hdl/nmie_consts.svh */
`ifndef NMIE_CONSTS_SVH
`define NMIE_CONSTS_SVH

// wishbone register byte addresses
`define NMIE_ADDR_CTRL 8'h00
`define NMIE_ADDR_STATUS 8'h04
`define NMIE_ADDR_SAVEDPC 8'h08
`define NMIE_ADDR_SAVEDPSW 8'h0C
`define NMIE_ADDR_CAUSE 8'h10
`define NMIE_ADDR_PC 8'h14
`define NMIE_ADDR_MREQ 8'h18
`define NMIE_ADDR_MLEVEL 8'h1C
`define NMIE_ADDR_VECTOR 8'h20
`define NMIE_ADDR_DECODE 8'h24
`define NMIE_ADDR_MISAVEDPC 8'h28
`define NMIE_ADDR_MISAVEDPSW 8'h2C

// status word bit positions
`define NMIE_PSW_ID 5
`define NMIE_PSW_EP 6
`define NMIE_PSW_NP 7

// ctrl register bits (write 1 commands except core state bits)
`define NMIE_CTRL_RETURN_FROM_INTERRUPT_OP 0
`define NMIE_CTRL_ABORTABLE 1
`define NMIE_CTRL_ILLEGAL 2
`define NMIE_CTRL_CLRNP 3
`define NMIE_CTRL_ACKMI 4

// vectors and codes
`define NMIE_VEC_NONMASKABLE_REQUEST_ZERO 32'h0000_0010
`define NMIE_VEC_NONMASKABLE_REQUEST_ONE 32'h0000_0020
`define NMIE_VEC_NONMASKABLE_REQUEST_TWO 32'h0000_0030
`define NMIE_VEC_ILLEGAL 32'h0000_0060
`define NMIE_MI_BASE 32'h0000_0340
`define NMIE_MI_STEP 32'h0000_0010
`define NMIE_MI_FIRST 6'h2C
`define NMIE_MI_COUNT 20
`define NMIE_INSN_BYTES 32'h0000_0004
`define NMIE_RESET_PC 32'h0000_0000
`define NMIE_RESET_PSW 32'h0000_0020

`endif

/* hdl/nmie_core.sv */
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "nmie_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: maskable sources 44..63 vector at 0x340 plus 0x10 per source step.
// R2: equal-level maskable requests resolve by lowest source number first.
// R3: abortable instruction in flight saves its own address, re-executes later.
// R4: illegal opcode saves address plus 4 as restore point.
// R5: nonmaskable requests are taken even with interrupts disabled.
// R6: rising edge on each request pin raises its nonmaskable request.
// R7: simultaneous requests: two over one over zero, lower ones discarded.
// R8: new request zero during zero service waits until return.
// R9: request one waits while in-service flag set, else preempts zero.
// R10: request two preempts request zero service at once.
// R11: only request zero returns correctly; one and two are not restorable.
// R12: request one or two during zero service overwrites saved pc.
// R13: during request one or two service nothing further is accepted.
// R14: entry saves restore address first, then status word.
// R15: entry writes code into upper cause half, lower half kept.
// R16: entry sets in-service and disable flags, clears exception flag, vectors.
// R17: return with exception flag 0, in-service 1 reloads pc and status.
// R18: after request one or two service the system must reset the core.
// R19: nonmaskable requests win over maskable ones in the same cycle.
// R20: each request edge is latched pending until accepted or discarded.
module nmie_core (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // nonmaskable request pins
   input wire logic [2:0] nmiRequestPin,
   // processor side
   input wire logic [31:0] nextPc,
   input wire logic [31:0] currentPc,
   // entry outputs
   output logic [31:0] programCounter,
   output logic entryTaken,
   output nmie_pkg::nmie_state_t serviceState
);
   import nmie_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      nmie_state_t state;
      logic [31:0] pc;
      logic [31:0] program_status_word;
      logic [31:0] savedPc;
      logic [31:0] savedPsw;
      logic [31:0] cause;
      logic [31:0] miSavedPc;
      logic [31:0] miSavedPsw;
      logic [19:0] miReq;
      logic [2:0] miLevel;
      logic [5:0] decodeSrc;
      logic abortable;
      logic entry;
      logic ack;
      logic [31:0] rdata;
      // accepted and discarded sources, cleared in the latch a cycle later;
      // the state change made at acceptance already blocks a second take
      logic [2:0] clearPend;
   } nmie_core_t;

   nmie_core_t st_reg;
   nmie_core_t st_next;
   logic [2:0] pending;

   // maskable vector for a source number (also its exception code)
   function automatic logic [31:0] miVector(input logic [5:0] src);
      logic [31:0] off;
      off = {26'h0, src} - {26'h0, 6'(`NMIE_MI_FIRST)};
      return `NMIE_MI_BASE + (off << 4); // R1
   endfunction

   // nonmaskable vector for a request index
   function automatic logic [31:0] nmiVector(input logic [1:0] idx);
      if (idx == 2'd2) begin
         return `NMIE_VEC_NONMASKABLE_REQUEST_TWO;
      end else if (idx == 2'd1) begin
         return `NMIE_VEC_NONMASKABLE_REQUEST_ONE;
      end else begin
         return `NMIE_VEC_NONMASKABLE_REQUEST_ZERO;
      end
   endfunction

   nmie_edge_latch u_nmie_edge_latch (
      .mclk(mclk),
      .rst(rst),
      .pinIn(nmiRequestPin),
      .clearIn(st_reg.clearPend),
      .pendingOut(pending)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic wr;
      logic rd;
      logic [31:0] wdata;
      logic [31:0] restorePc;
      logic take;
      logic [1:0] takeIdx;
      logic doReti;
      logic miTake;
      logic [4:0] miIdx;
      logic [31:0] nmiVec;
      logic [31:0] miVec;
      wr = 1'b0;
      rd = 1'b0;
      wdata = '0;
      restorePc = '0;
      take = 1'b0;
      takeIdx = 2'd0;
      doReti = 1'b0;
      miTake = 1'b0;
      miIdx = 5'd0;
      nmiVec = '0;
      miVec = '0;
      st_next = st_reg;
      st_next.entry = 1'b0;
      st_next.ack = 1'b0;
      st_next.clearPend = 3'b000;

      if (wb_cyc_i && wb_stb_i && !st_reg.ack) begin
         wr = wb_we_i;
         rd = !wb_we_i;
      end
      for (int b = 0; b < 4; b++) begin
         wdata[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : 8'h00;
      end

      // restore address: abortable op re-executes, else next instruction
      restorePc = st_reg.abortable ? currentPc : nextPc; // R3

      if (wr) begin
         st_next.ack = 1'b1;
         if (wb_adr_i == `NMIE_ADDR_CTRL) begin
            st_next.abortable = wdata[`NMIE_CTRL_ABORTABLE];
            doReti = wdata[`NMIE_CTRL_RETURN_FROM_INTERRUPT_OP];
            if (wdata[`NMIE_CTRL_CLRNP]) begin
               st_next.program_status_word[`NMIE_PSW_NP] = 1'b0;
            end
            if (wdata[`NMIE_CTRL_ILLEGAL]) begin
               st_next.miSavedPc = currentPc + `NMIE_INSN_BYTES; // R4
               st_next.pc = `NMIE_VEC_ILLEGAL;
            end
            if (wdata[`NMIE_CTRL_ACKMI]) begin
               st_next.program_status_word[`NMIE_PSW_ID] = 1'b0;
            end
         end else if (wb_adr_i == `NMIE_ADDR_MREQ) begin
            st_next.miReq = st_reg.miReq | wdata[19:0];
         end else if (wb_adr_i == `NMIE_ADDR_MLEVEL) begin
            st_next.miLevel = wdata[2:0];
         end else if (wb_adr_i == `NMIE_ADDR_DECODE) begin
            st_next.decodeSrc = wdata[5:0];
         end
      end

      // return from interrupt
      if (doReti) begin
         if (!st_reg.program_status_word[`NMIE_PSW_EP] && st_reg.program_status_word[`NMIE_PSW_NP]) begin
            st_next.pc = st_reg.savedPc; // R17
            st_next.program_status_word = st_reg.savedPsw; // R17
            st_next.state = NMIE_IDLE; // R11
         end else if (!st_reg.program_status_word[`NMIE_PSW_EP]) begin
            st_next.pc = st_reg.miSavedPc;
            st_next.program_status_word = st_reg.miSavedPsw;
            st_next.state = NMIE_IDLE;
         end
      end

      // arbitration, ignores the disable flag
      if (!doReti) begin // R5
         case (st_reg.state)
            NMIE_IDLE, NMIE_SERVEMI: begin
               if (pending[2]) begin
                  take = 1'b1;
                  takeIdx = 2'd2; // R7
               end else if (pending[1]) begin
                  take = 1'b1;
                  takeIdx = 2'd1;
               end else if (pending[0]) begin
                  take = 1'b1;
                  takeIdx = 2'd0;
               end
            end
            NMIE_SERVE0: begin
               if (pending[2]) begin
                  take = 1'b1; // R10
                  takeIdx = 2'd2;
               end else if (pending[1] && !st_reg.program_status_word[`NMIE_PSW_NP]) begin
                  take = 1'b1; // R9
                  takeIdx = 2'd1;
               end
               // request zero stays pending until return // R8
            end
            NMIE_SERVE12: begin
               take = 1'b0; // R13 R18
            end
            default: begin
               take = 1'b0;
            end
         endcase
      end

      if (take) begin
         nmiVec = nmiVector(takeIdx);
         st_next.savedPc = restorePc; // R14 R12
         st_next.savedPsw = st_reg.program_status_word; // R14
         st_next.cause[31:16] = nmiVec[15:0]; // R15
         st_next.program_status_word[`NMIE_PSW_NP] = 1'b1; // R16
         st_next.program_status_word[`NMIE_PSW_ID] = 1'b1; // R16
         st_next.program_status_word[`NMIE_PSW_EP] = 1'b0; // R16
         st_next.pc = nmiVec; // R16
         st_next.state = (takeIdx == 2'd0) ? NMIE_SERVE0 : NMIE_SERVE12;
         st_next.entry = 1'b1;
         // accepted source cleared, lower simultaneous ones discarded
         for (int i = 0; i < 3; i++) begin
            if (i <= int'(takeIdx)) begin
               st_next.clearPend[i] = pending[i]; // R7 R20
            end
         end
      end else if (st_reg.state == NMIE_IDLE && !st_reg.program_status_word[`NMIE_PSW_ID] &&
                   !st_reg.program_status_word[`NMIE_PSW_NP] && !doReti) begin
         // maskable take only when no nonmaskable is pending
         for (int s = `NMIE_MI_COUNT - 1; s >= 0; s--) begin
            if (st_reg.miReq[s]) begin
               miTake = 1'b1; // R19
               miIdx = 5'(s); // R2
            end
         end
         if (miTake) begin
            st_next.miReq[miIdx] = 1'b0;
            st_next.miSavedPc = restorePc;
            st_next.miSavedPsw = st_reg.program_status_word;
            miVec = miVector(6'(`NMIE_MI_FIRST) + {1'b0, miIdx}); // R1
            st_next.cause[15:0] = miVec[15:0];
            st_next.program_status_word[`NMIE_PSW_ID] = 1'b1;
            st_next.program_status_word[`NMIE_PSW_EP] = 1'b0;
            st_next.pc = miVec; // R1
            st_next.state = NMIE_SERVEMI;
            st_next.entry = 1'b1;
         end
      end

      // read mux
      if (rd) begin
         st_next.ack = 1'b1;
         if (wb_adr_i == `NMIE_ADDR_CTRL) begin
            st_next.rdata = {30'h0, st_reg.abortable, 1'b0};
         end else if (wb_adr_i == `NMIE_ADDR_STATUS) begin
            st_next.rdata = st_reg.program_status_word;
         end else if (wb_adr_i == `NMIE_ADDR_SAVEDPC) begin
            st_next.rdata = st_reg.savedPc;
         end else if (wb_adr_i == `NMIE_ADDR_SAVEDPSW) begin
            st_next.rdata = st_reg.savedPsw;
         end else if (wb_adr_i == `NMIE_ADDR_CAUSE) begin
            st_next.rdata = st_reg.cause;
         end else if (wb_adr_i == `NMIE_ADDR_PC) begin
            st_next.rdata = st_reg.pc;
         end else if (wb_adr_i == `NMIE_ADDR_MREQ) begin
            st_next.rdata = {12'h0, st_reg.miReq};
         end else if (wb_adr_i == `NMIE_ADDR_MLEVEL) begin
            st_next.rdata = {25'h0, pending, st_reg.state[3:1], st_reg.miLevel[0]};
         end else if (wb_adr_i == `NMIE_ADDR_VECTOR) begin
            st_next.rdata = miVector(st_reg.decodeSrc);
         end else if (wb_adr_i == `NMIE_ADDR_DECODE) begin
            st_next.rdata = {26'h0, st_reg.decodeSrc};
         end else if (wb_adr_i == `NMIE_ADDR_MISAVEDPC) begin
            st_next.rdata = st_reg.miSavedPc;
         end else if (wb_adr_i == `NMIE_ADDR_MISAVEDPSW) begin
            st_next.rdata = st_reg.miSavedPsw;
         end else begin
            st_next.rdata = '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg.state <= NMIE_IDLE;
         st_reg.pc <= `NMIE_RESET_PC;
         st_reg.program_status_word <= `NMIE_RESET_PSW;
         st_reg.savedPc <= '0;
         st_reg.savedPsw <= '0;
         st_reg.cause <= '0;
         st_reg.miSavedPc <= '0;
         st_reg.miSavedPsw <= '0;
         st_reg.miReq <= '0;
         st_reg.miLevel <= '0;
         st_reg.decodeSrc <= `NMIE_MI_FIRST;
         st_reg.abortable <= 1'b0;
         st_reg.entry <= 1'b0;
         st_reg.ack <= 1'b0;
         st_reg.rdata <= '0;
         st_reg.clearPend <= 3'b000;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;
   assign programCounter = st_reg.pc;
   assign entryTaken = st_reg.entry;
   assign serviceState = st_reg.state;
endmodule // nmie_core

/* hdl/nmie_edge_latch.sv */
`timescale 1ns/1ps
`include "nmie_consts.svh"

// rising-edge detectors with pending latches, capture wins over clear
module nmie_edge_latch (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request pins
   input wire logic [2:0] pinIn,
   // clear strobes
   input wire logic [2:0] clearIn,
   // pending flags
   output logic [2:0] pendingOut
);
   typedef struct packed {
      logic [2:0] lastPin;
      logic [2:0] pending;
   } nmie_edge_t;

   nmie_edge_t st_reg;
   nmie_edge_t st_next;

   always_comb begin
      logic [2:0] rise;
      rise = pinIn & ~st_reg.lastPin;
      st_next = st_reg;
      st_next.lastPin = pinIn;
      st_next.pending = (st_reg.pending & ~clearIn) | rise; // R6 R20
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         // a pin already high at release must not read as a fresh edge
         st_reg.lastPin <= pinIn;
         st_reg.pending <= 3'b000;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pendingOut = st_reg.pending;
endmodule // nmie_edge_latch

/* hdl/nmie_pkg.sv */
package nmie_pkg;
   typedef enum logic [3:0] {
      NMIE_IDLE = 4'h1,
      NMIE_SERVE0 = 4'h2,
      NMIE_SERVE12 = 4'h4,
      NMIE_SERVEMI = 4'h8
   } nmie_state_t;
endpackage

/* sim/nmie_core_sva.sv */
`timescale 1ns/1ps
module nmie_core_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // requests and entry
   input wire logic [2:0] nmiRequestPin,
   input wire logic [31:0] programCounter,
   input wire logic entryTaken,
   input wire nmie_pkg::nmie_state_t serviceState
);
   import nmie_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   idle_two_a: assert property ($rose(nmiRequestPin[2]) && serviceState == NMIE_IDLE |-> ##2
      programCounter == 32'h0000_0030 && serviceState == NMIE_SERVE12)
      else $error("request two not taken");
   same_time_a: assert property ($rose(nmiRequestPin[1]) && $rose(nmiRequestPin[0]) &&
      !nmiRequestPin[2] && serviceState == NMIE_IDLE |-> ##2 programCounter == 32'h0000_0020)
      else $error("simultaneous order wrong");
   two_preempt_a: assert property (serviceState == NMIE_SERVE0 && $rose(nmiRequestPin[2]) |-> ##2
      programCounter == 32'h0000_0030 && serviceState == NMIE_SERVE12)
      else $error("request two did not preempt");
   zero_hold_a: assert property (serviceState == NMIE_SERVE0 && $rose(nmiRequestPin[0]) &&
      nmiRequestPin[2:1] == 2'h0 |=> !entryTaken [*3])
      else $error("nested request zero taken");
   lock_a: assert property (serviceState == NMIE_SERVE12 |=>
      serviceState == NMIE_SERVE12 && !entryTaken)
      else $error("entry during locked service");
   vec_zero_a: assert property (entryTaken && serviceState == NMIE_SERVE0 |->
      programCounter == 32'h0000_0010)
      else $error("wrong vector zero");
   vec_mask_a: assert property (entryTaken && serviceState == NMIE_SERVEMI |->
      programCounter[3:0] == 4'h0 && programCounter >= 32'h0000_0340 &&
      programCounter <= 32'h0000_0470)
      else $error("wrong maskable vector");
   cover property (serviceState == NMIE_SERVE0 && $rose(nmiRequestPin[2]));
   cover property (entryTaken && serviceState == NMIE_SERVEMI);
   cover property (serviceState == NMIE_SERVE0 && $rose(nmiRequestPin[0]));
endmodule // nmie_core_sva

bind nmie_core nmie_core_sva u_nmie_core_sva (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .nmiRequestPin(nmiRequestPin),
   .programCounter(programCounter), .entryTaken(entryTaken), .serviceState(serviceState));

/* sim/nmie_source_model.sv */
`timescale 1ns/1ps
// request sources: a fire bit raises its pin, which then stays high holdLen+1 cycles
module nmie_source_model (
   // clock
   input wire logic mclk,
   // commands
   input wire logic [2:0] fire,
   input wire logic [3:0] holdLen,
   // request pins
   output logic [2:0] nmiRequestPin
);
   logic [3:0] age;
   initial begin
      nmiRequestPin = 3'h0;
      age = 4'h0;
   end
   always @(posedge mclk) begin
      if (fire != 3'h0) begin
         nmiRequestPin <= nmiRequestPin | fire;
         age <= 4'h0;
      end else if (age >= holdLen) begin
         nmiRequestPin <= 3'h0;
      end else begin
         age <= age + 4'h1;
      end
   end
endmodule // nmie_source_model

/* sim/test_nonmaskable_interrupt_entry.sv */
`timescale 1ns/1ps
`include "nmie_consts.svh"
module test_nonmaskable_interrupt_entry;
   import nmie_pkg::*;
   logic mclk, rst, wbCyc, wbStb, wbWe, wbAck, entryTaken;
   logic [7:0] wbAdr;
   logic [31:0] wbDatI, wbDatO, nextPc, currentPc, pcOut, rd;
   logic [2:0] fire, pins;
   logic [3:0] holdLen;
   nmie_state_t state;
   int badCount, cmpCount, cycles;
   nmie_core u_nmie_core (.mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .nmiRequestPin(pins), .nextPc(nextPc),
      .currentPc(currentPc), .programCounter(pcOut), .entryTaken(entryTaken),
      .serviceState(state));
   nmie_source_model u_nmie_source_model (.mclk(mclk), .fire(fire), .holdLen(holdLen),
      .nmiRequestPin(pins));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", badCount, cmpCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wbCycle(input logic [7:0] adr, input logic we, input logic [31:0] wd);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= wd;
      @(posedge mclk);
      while (wbAck !== 1'b1) begin
         @(posedge mclk);
      end
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdChk(input logic [7:0] adr, input string what, input logic [31:0] exp);
      wbCycle(adr, 1'b0, 32'h0);
      check(what, exp, rd);
   endtask
   task automatic ret();
      wbCycle(`NMIE_ADDR_CTRL, 1'b1, 32'h1);
      repeat (4) @(posedge mclk);
   endtask
   task automatic raise(input logic [2:0] m);
      fire <= m;
      @(posedge mclk);
      fire <= 3'h0;
      repeat (12) @(posedge mclk);
   endtask
   task automatic expect_at(input nmie_state_t s, input logic [31:0] pc);
      check("state", {28'h0, s}, {28'h0, state});
      check("pc", pc, pcOut);
   endtask
   task automatic doReset();
      rst <= 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         badCount++;
         conclude();
      end
   end
   initial begin
      {rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, fire} = {1'b1, 46'h0};
      {badCount, cmpCount, cycles} = {32'h0, 32'h0, 32'h0};
      {holdLen, nextPc, currentPc} = {4'h2, 32'h1000, 32'h0500};
      doReset();
      rdChk(`NMIE_ADDR_STATUS, "status", 32'h20);
      rdChk(8'h30, "unmapped", 32'h0);
      for (int s = 44; s < 64; s++) begin
         wbCycle(`NMIE_ADDR_DECODE, 1'b1, 32'(s));
         rdChk(`NMIE_ADDR_VECTOR, "vector", 32'h340 + 32'(s - 44) * 32'h10);
      end
      raise(3'h1);
      expect_at(NMIE_SERVE0, 32'h10);
      rdChk(`NMIE_ADDR_SAVEDPC, "savedPc", 32'h1000);
      rdChk(`NMIE_ADDR_SAVEDPSW, "savedPsw", 32'h20);
      rdChk(`NMIE_ADDR_STATUS, "status", 32'hA0);
      rdChk(`NMIE_ADDR_CAUSE, "cause", 32'h0010_0000);
      nextPc <= 32'h2000;
      ret();
      expect_at(NMIE_IDLE, 32'h1000);
      rdChk(`NMIE_ADDR_STATUS, "status", 32'h20);
      raise(3'h1);
      raise(3'h1);
      expect_at(NMIE_SERVE0, 32'h10);
      nextPc <= 32'h3000;
      ret();
      rdChk(`NMIE_ADDR_SAVEDPC, "savedPc", 32'h3000);
      raise(3'h2);
      expect_at(NMIE_SERVE0, 32'h10);
      ret();
      expect_at(NMIE_SERVE12, 32'h20);
      rdChk(`NMIE_ADDR_CAUSE, "cause", 32'h0020_0000);
      raise(3'h5);
      expect_at(NMIE_SERVE12, 32'h20);
      doReset();
      raise(3'h1);
      wbCycle(`NMIE_ADDR_CTRL, 1'b1, 32'h8);
      nextPc <= 32'h4000;
      holdLen <= 4'h8;
      raise(3'h2);
      expect_at(NMIE_SERVE12, 32'h20);
      rdChk(`NMIE_ADDR_SAVEDPC, "savedPc", 32'h4000);
      doReset();
      raise(3'h1);
      raise(3'h4);
      expect_at(NMIE_SERVE12, 32'h30);
      rdChk(`NMIE_ADDR_CAUSE, "cause", 32'h0030_0000);
      for (int m = 3; m < 8; m++) begin
         doReset();
         raise(3'(m));
         expect_at(NMIE_SERVE12, (m > 3) ? 32'h30 : 32'h20);
         rdChk(`NMIE_ADDR_MLEVEL, "pending", 32'h4);
      end
      doReset();
      wbCycle(`NMIE_ADDR_CTRL, 1'b1, 32'h4);
      rdChk(`NMIE_ADDR_PC, "pc", 32'h60);
      rdChk(`NMIE_ADDR_MISAVEDPC, "miSavedPc", 32'h504);
      wbCycle(`NMIE_ADDR_CTRL, 1'b1, 32'h2);
      raise(3'h1);
      rdChk(`NMIE_ADDR_SAVEDPC, "savedPc", 32'h500);
      // pin still high when reset is released: no request may follow
      holdLen <= 4'hF;
      fire <= 3'h1;
      @(posedge mclk);
      fire <= 3'h0;
      doReset();
      repeat (4) @(posedge mclk);
      expect_at(NMIE_IDLE, 32'h0);
      holdLen <= 4'h8;
      doReset();
      wbCycle(`NMIE_ADDR_MREQ, 1'b1, 32'h24);
      // request zero becomes pending in the cycle the disable flag clears
      fire <= 3'h1;
      @(posedge mclk);
      fire <= 3'h0;
      wbCycle(`NMIE_ADDR_CTRL, 1'b1, 32'h10);
      repeat (4) @(posedge mclk);
      expect_at(NMIE_SERVE0, 32'h10);
      ret();
      expect_at(NMIE_SERVEMI, 32'h360);
      rdChk(`NMIE_ADDR_CAUSE, "cause", 32'h0010_0360);
      conclude();
   end
endmodule // test_nonmaskable_interrupt_entry
